/* core/dee_array.sv */
// byte storage array with one write port and two read ports
`timescale 1ns/100ps
module dee_array (
  input  wire logic       pclk,
  input  wire logic       clk_en,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr_a,
  output logic      [7:0] rdata_a,
  input  wire logic [7:0] raddr_b,
  output logic      [7:0] rdata_b
);

  logic [7:0] mem_r [dee_pkg::ARRAY_DEPTH];

  // cell update, frozen while clock enable is low
  always_ff @(posedge pclk) begin
    if (clk_en && we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // asynchronous read ports
  assign rdata_a = mem_r[raddr_a];
  assign rdata_b = mem_r[raddr_b];

endmodule

/* core/dee_ctrl.sv */
// data eeprom controller with apb register slave and self-timed writes
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
// How it works
// - eight-bit data register and address register select the eeprom byte
// - array holds 256 bytes, or 64 in the small variant
// - small variant reads address bit seven back as zero
// - each byte write erases the cell first, then programs it
// - write duration timed by an internal counter, not software
// - with protection on, core works normally, programmer reads zeros
// - control register has four low bits only, upper bits read zero
// - software only sets read/write start bits, hardware clears them
// - writes need write enable set; write enable clear after reset
// - write aborted by master clear or watchdog sets the error flag
// - aborting reset clears data and address registers
// - write end sets flag bit seven, only software clears it
// - unlock port has no storage and reads zero
// - read start loads the addressed byte next cycle and self-clears
// - data register keeps a read result until next read or write
// - write starts only after 0x55, 0xAA, then write start, back to back
// - clearing write enable does not disturb a running write
// - writes blocked while the power-up timer runs
module dee_ctrl #(
  parameter int unsigned WRITE_CYCLES = dee_pkg::WRITE_CYCLES,
  parameter bit          BIG_VARIANT  = 1'b1
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            clk_en,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [dee_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [dee_pkg::APB_DATA_W-1:0]  pwdata,
  output logic      [dee_pkg::APB_DATA_W-1:0]  prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            external_master_clear,
  input  wire logic                            watchdog_timeout,
  input  wire logic                            power_up_timer_busy,
  input  wire logic                            data_protect_setting,
  input  wire logic                            prog_rd_en,
  input  wire logic [7:0]                      prog_addr,
  output logic      [7:0]                      prog_rdata,
  output logic                                 write_busy
);

  // phase lengths derived from the total write time
  localparam logic [dee_pkg::WCNT_W-1:0] ERASE_LAST = dee_pkg::WCNT_W'(WRITE_CYCLES / 2 - 1);
  localparam logic [dee_pkg::WCNT_W-1:0] PROG_LAST  = dee_pkg::WCNT_W'(WRITE_CYCLES - WRITE_CYCLES / 2 - 1);

  // register word hit for a given index
  function automatic logic reg_hit(input logic [dee_pkg::APB_ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

  // array cell, 64-byte wrap in the small variant
  // array cell for a software address
  function automatic logic [7:0] cell_of(input logic [7:0] a);
    return BIG_VARIANT ? a : (a & dee_pkg::SMALL_ARRAY_MASK);
  endfunction

  // register state
  logic [31:0]              prdata_r, prdata_nxt;
  logic                     pready_r, pready_nxt;
  logic                     pslverr_r, pslverr_nxt;
  logic [7:0]               data_r, data_nxt;
  logic [7:0]               addr_r, addr_nxt;
  logic                     err_r, err_nxt;
  logic                     write_enable_bit_r, write_enable_bit_nxt;
  logic                     wr_r, wr_nxt;
  logic                     rd_r, rd_nxt;
  logic                     done_r, done_nxt;
  logic [7:0]               prog_r, prog_nxt;
  logic [7:0]               waddr_r, waddr_nxt;
  logic [7:0]               wdata_r, wdata_nxt;
  logic [dee_pkg::WCNT_W-1:0] cnt_r, cnt_nxt;
  dee_pkg::dee_unlock_t     unl_r, unl_nxt;
  dee_pkg::dee_write_t      wst_r, wst_nxt;

  // array port signals
  logic       arr_we;
  logic [7:0] arr_wdata;
  logic [7:0] arr_rd_core;
  logic [7:0] arr_rd_prog;

  // bus decode
  logic setup;
  logic access;
  logic wr_acc;
  logic mapped;
  logic abort_evt;
  logic start_ok;

  assign setup     = psel && !penable;
  assign access    = psel && penable && pready_r;
  assign wr_acc    = access && pwrite;
  assign abort_evt = external_master_clear || watchdog_timeout;
  assign mapped    = reg_hit(paddr, dee_pkg::DATA_IDX) || reg_hit(paddr, dee_pkg::ADDR_IDX)
                  || reg_hit(paddr, dee_pkg::CTRL_IDX) || reg_hit(paddr, dee_pkg::UNLOCK_IDX)
                  || reg_hit(paddr, dee_pkg::FLAG_IDX);

  // storage array
  dee_array u_array (
    .pclk    (pclk),
    .clk_en  (clk_en),
    .we      (arr_we),
    .waddr   (cell_of(waddr_r)),
    .wdata   (arr_wdata),
    .raddr_a (cell_of(addr_r)),
    .rdata_a (arr_rd_core),
    .raddr_b (cell_of(prog_addr)),
    .rdata_b (arr_rd_prog)
  );

  // next state of all registers
  always_comb begin
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    data_nxt    = data_r;
    addr_nxt    = addr_r;
    err_nxt     = err_r;
    write_enable_bit_nxt    = write_enable_bit_r;
    wr_nxt      = wr_r;
    rd_nxt      = rd_r;
    done_nxt    = done_r;
    prog_nxt    = prog_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    cnt_nxt     = cnt_r;
    unl_nxt     = unl_r;
    wst_nxt     = wst_r;
    arr_we      = 1'b0;
    arr_wdata   = wdata_r;
    start_ok    = 1'b0;

    // setup phase: prepare answer for the access phase
    if (setup) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt  = 32'h0000_0000;
      if (reg_hit(paddr, dee_pkg::DATA_IDX)) begin
        prdata_nxt[7:0] = data_r;
      end
      if (reg_hit(paddr, dee_pkg::ADDR_IDX)) begin
        prdata_nxt[7:0] = BIG_VARIANT ? addr_r : (addr_r & dee_pkg::SMALL_READ_MASK);
      end
      if (reg_hit(paddr, dee_pkg::CTRL_IDX)) begin
        prdata_nxt[3:0] = {err_r, write_enable_bit_r, wr_r, rd_r};
      end
      if (reg_hit(paddr, dee_pkg::FLAG_IDX)) begin
        prdata_nxt[dee_pkg::FLAG_DONE_BIT] = done_r;
      end
      // unlock port reads zero, nothing stored
    end

    if (access) begin
      unl_nxt = dee_pkg::UNL_IDLE;
      if (wr_acc && reg_hit(paddr, dee_pkg::UNLOCK_IDX)) begin
        if (pwdata[7:0] == dee_pkg::UNLOCK_KEY1) begin
          unl_nxt = dee_pkg::UNL_KEY1;
        end else if (pwdata[7:0] == dee_pkg::UNLOCK_KEY2 && unl_r == dee_pkg::UNL_KEY1) begin
          unl_nxt = dee_pkg::UNL_ARMED;
        end
      end
    end

    // software register writes
    if (wr_acc) begin
      if (reg_hit(paddr, dee_pkg::DATA_IDX)) begin
        data_nxt = pwdata[7:0];
      end
      if (reg_hit(paddr, dee_pkg::ADDR_IDX)) begin
        addr_nxt = pwdata[7:0];
      end
      if (reg_hit(paddr, dee_pkg::CTRL_IDX)) begin
        err_nxt  = pwdata[dee_pkg::CTRL_ERR_BIT];
        write_enable_bit_nxt = pwdata[dee_pkg::CTRL_WRITE_ENABLE_BIT_BIT];
        if (pwdata[dee_pkg::CTRL_RD_BIT]) begin
          rd_nxt = 1'b1;
        end
        start_ok = pwdata[dee_pkg::CTRL_WR_BIT] && unl_r == dee_pkg::UNL_ARMED && write_enable_bit_r
                && !power_up_timer_busy && wst_r == dee_pkg::WR_IDLE;
      end
      if (reg_hit(paddr, dee_pkg::FLAG_IDX)) begin
        done_nxt = pwdata[dee_pkg::FLAG_DONE_BIT];
      end
    end

    // read result next cycle, start bit self-clears
    // data held until next read or software write
    if (rd_r) begin
      data_nxt = arr_rd_core;
      rd_nxt   = 1'b0;
    end

    // write engine
    case (wst_r)
      dee_pkg::WR_IDLE: begin
        if (start_ok) begin
          // address and data latched so later changes do not matter
          wr_nxt    = 1'b1;
          waddr_nxt = addr_r;
          wdata_nxt = data_r;
          cnt_nxt   = '0;
          wst_nxt   = dee_pkg::WR_ERASE;
        end
      end
      dee_pkg::WR_ERASE: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == ERASE_LAST) begin
          arr_we    = 1'b1;
          arr_wdata = dee_pkg::ERASED_BYTE;
          cnt_nxt   = '0;
          wst_nxt   = dee_pkg::WR_PROG;
        end
      end
      dee_pkg::WR_PROG: begin
        cnt_nxt = cnt_r + 1'b1;
        // start bit holds until the count expires
        if (cnt_r == PROG_LAST) begin
          arr_we    = 1'b1;
          arr_wdata = wdata_r;
          wr_nxt    = 1'b0;
          wst_nxt   = dee_pkg::WR_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: begin
        wst_nxt = dee_pkg::WR_IDLE;
      end
    endcase

    // programmer port reads zeros under protection
    if (prog_rd_en) begin
      prog_nxt = data_protect_setting ? 8'h00 : arr_rd_prog;
    end

    // aborting reset from master clear or watchdog
    if (abort_evt) begin
      // error flag when a write was cut short
      if (wst_r != dee_pkg::WR_IDLE) begin
        err_nxt = 1'b1;
      end
      data_nxt = dee_pkg::DATA_RST;
      addr_nxt = dee_pkg::ADDR_RST;
      write_enable_bit_nxt = dee_pkg::BIT_RST;
      wr_nxt   = dee_pkg::BIT_RST;
      rd_nxt   = dee_pkg::BIT_RST;
      arr_we   = 1'b0;
      unl_nxt  = dee_pkg::UNL_IDLE;
      wst_nxt  = dee_pkg::WR_IDLE;
      cnt_nxt  = '0;
    end
  end

  // register update, frozen while clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      data_r    <= dee_pkg::DATA_RST;
      addr_r    <= dee_pkg::ADDR_RST;
      err_r     <= dee_pkg::BIT_RST;
      write_enable_bit_r    <= dee_pkg::BIT_RST;
      wr_r      <= dee_pkg::BIT_RST;
      rd_r      <= dee_pkg::BIT_RST;
      done_r    <= dee_pkg::BIT_RST;
      prog_r    <= 8'h00;
      waddr_r   <= dee_pkg::ADDR_RST;
      wdata_r   <= dee_pkg::DATA_RST;
      cnt_r     <= '0;
      unl_r     <= dee_pkg::UNL_IDLE;
      wst_r     <= dee_pkg::WR_IDLE;
    end else if (clk_en) begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      data_r    <= data_nxt;
      addr_r    <= addr_nxt;
      err_r     <= err_nxt;
      write_enable_bit_r    <= write_enable_bit_nxt;
      wr_r      <= wr_nxt;
      rd_r      <= rd_nxt;
      done_r    <= done_nxt;
      prog_r    <= prog_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      cnt_r     <= cnt_nxt;
      unl_r     <= unl_nxt;
      wst_r     <= wst_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign prog_rdata = prog_r;
  assign write_busy = wr_r;

endmodule

/* core/dee_pkg.sv */
// constants, register map and state codes of the data eeprom controller
package dee_pkg;

  // apb geometry
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] DATA_IDX   = 8'h9a;
  localparam logic [7:0] ADDR_IDX   = 8'h9b;
  localparam logic [7:0] CTRL_IDX   = 8'h9c;
  localparam logic [7:0] UNLOCK_IDX = 8'h9d;
  localparam logic [7:0] FLAG_IDX   = 8'h0c;

  // control register fields
  localparam int unsigned CTRL_ERR_BIT  = 3;
  localparam int unsigned CTRL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int unsigned CTRL_WR_BIT   = 1;
  localparam int unsigned CTRL_RD_BIT   = 0;

  // peripheral flag register field
  localparam int unsigned FLAG_DONE_BIT = 7;

  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic       BIT_RST  = 1'b0;

  // unlock keys and erased cell value
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // address masks for the smaller variant
  localparam logic [7:0] SMALL_READ_MASK  = 8'h7f;
  localparam logic [7:0] SMALL_ARRAY_MASK = 8'h3f;

  // array size
  localparam int unsigned ARRAY_DEPTH = 256;

  // self-timed write duration
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned WCNT_W        = 20;

  // unlock sequence states
  typedef enum logic [2:0] {
    UNL_IDLE  = 3'b001,
    UNL_KEY1  = 3'b010,
    UNL_ARMED = 3'b100
  } dee_unlock_t;

  // write engine states
  typedef enum logic [2:0] {
    WR_IDLE  = 3'b001,
    WR_ERASE = 3'b010,
    WR_PROG  = 3'b100
  } dee_write_t;

endpackage

/* verif/dee_core_model.sv */
// processor core model issuing apb transfers
`timescale 1ns/100ps
module dee_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic             err
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go && !psel) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        rdata <= prdata;
        err <= pslverr;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        done <= 1'b1;
      end
    end
  end
endmodule

/* verif/dee_ctrl_sva.sv */
// assertion checker for the data eeprom controller
`timescale 1ns/100ps
module dee_ctrl_sva #(
  parameter int unsigned WRITE_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_master_clear,
  input wire logic        watchdog_timeout,
  input wire logic        power_up_timer_busy,
  input wire logic        data_protect_setting,
  input wire logic        prog_rd_en,
  input wire logic [7:0]  prog_rdata,
  input wire logic        write_busy
);
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic        abort;
  logic        ctrl_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // busy cycle count and event helpers
  assign abort = external_master_clear | watchdog_timeout;
  assign ctrl_wr = psel & penable & pwrite & (paddr == 12'h270);
  assign cnt_nxt = write_busy ? cnt_r + 20'h0_0001 : 20'h0_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 20'h0_0000;
    else cnt_r <= cnt_nxt;
  end
  property p_ready; psel && !penable && clk_en |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("bad answer timing");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unlock; pready && !pwrite && paddr == 12'h274 |-> prdata == 32'h0000_0000; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock port read nonzero");
  property p_wtime; $fell(write_busy) |-> cnt_r == WRITE_CYCLES || $past(abort); endproperty
  a_wtime: assert property (p_wtime) else $error("write length wrong");
  property p_wmax; cnt_r <= WRITE_CYCLES; endproperty
  a_wmax: assert property (p_wmax) else $error("write runs too long");
  property p_abort; abort |=> !write_busy; endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop write");
  property p_pwrt; power_up_timer_busy && !write_busy |=> !write_busy; endproperty
  a_pwrt: assert property (p_pwrt) else $error("write during power-up");
  property p_prot; prog_rd_en && data_protect_setting |=> prog_rdata == 8'h00; endproperty
  a_prot: assert property (p_prot) else $error("protected read leaked");
  property p_start; $rose(write_busy) |-> $past(ctrl_wr); endproperty
  a_start: assert property (p_start) else $error("write began without control write");
  c_done: cover property ($fell(write_busy) && !$past(abort));
  c_abort: cover property (abort && write_busy);
  c_err: cover property (pslverr);
endmodule
bind dee_ctrl dee_ctrl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) sva_u (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .external_master_clear, .watchdog_timeout, .power_up_timer_busy,
  .data_protect_setting, .prog_rd_en, .prog_rdata, .write_busy);

/* verif/testbench.sv */
// self-checking bench of the data eeprom controller
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t got %h want %h", $time, g, e); end end
module testbench;
  localparam logic [11:0] A_DAT = {2'b00, dee_pkg::DATA_IDX, 2'b00};
  localparam logic [11:0] A_ADR = {2'b00, dee_pkg::ADDR_IDX, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, dee_pkg::CTRL_IDX, 2'b00};
  localparam logic [11:0] A_UNL = {2'b00, dee_pkg::UNLOCK_IDX, 2'b00};
  localparam logic [11:0] A_FLG = {2'b00, dee_pkg::FLAG_IDX, 2'b00};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [11:0] ad = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic        mc = 1'b0;
  logic        wdt = 1'b0;
  logic        ptb = 1'b0;
  logic        dps = 1'b0;
  logic        prd = 1'b0;
  logic [7:0]  pad = 8'h00;
  logic        psel, penable, pwrite, pready, pslverr, done, err, write_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0]  prog_rdata;
  logic [31:0] prdata_s;
  int          mismatches = 0;
  int          n_checks = 0;
  dee_ctrl #(.WRITE_CYCLES(16), .BIG_VARIANT(1'b1)) dut_u (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_master_clear(mc), .watchdog_timeout(wdt),
    .power_up_timer_busy(ptb), .data_protect_setting(dps), .prog_rd_en(prd), .prog_addr(pad), .prog_rdata,
    .write_busy);
  // small variant on the same bus, only its read data is watched
  dee_ctrl #(.WRITE_CYCLES(16), .BIG_VARIANT(1'b0)) dut_s_u (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(prdata_s), .pready(), .pslverr(), .external_master_clear(mc),
    .watchdog_timeout(wdt), .power_up_timer_busy(ptb), .data_protect_setting(dps), .prog_rd_en(prd),
    .prog_addr(pad), .prog_rdata(), .write_busy());
  dee_core_model core_u (.pclk, .presetn, .go, .wr, .addr(ad), .wdata(wd), .pready, .pslverr, .prdata, .psel,
    .penable, .pwrite, .paddr, .pwdata, .done, .rdata, .err);
  always #4 pclk = ~pclk;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge pclk);
    go <= 1'b0;
    do @(negedge pclk); while (done !== 1'b1 && ++n < 50);
    if (n >= 50) mismatches++;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rdata, e)
  endtask
  task automatic start(input logic [7:0] c);
    xfer(1'b1, A_UNL, {24'h00_0000, dee_pkg::UNLOCK_KEY1});
    xfer(1'b1, A_UNL, {24'h00_0000, dee_pkg::UNLOCK_KEY2});
    xfer(1'b1, A_CTL, {24'h00_0000, c});
  endtask
  task automatic t_regs;
    rd(A_DAT, 32'h0000_0000);
    rd(A_CTL, 32'h0000_0000);
    rd(A_FLG, 32'h0000_0000);
    xfer(1'b1, A_ADR, 32'hffff_ff3c);
    rd(A_ADR, 32'h0000_003c);
    xfer(1'b1, A_ADR, 32'h0000_00bc);
    rd(A_ADR, 32'h0000_00bc);
    `CHK(prdata_s, 32'h0000_003c)
    xfer(1'b1, A_CTL, 32'hffff_fff4);
    rd(A_CTL, 32'h0000_0004);
    xfer(1'b1, A_UNL, 32'h0000_0055);
    rd(A_UNL, 32'h0000_0000);
    rd(12'h000, 32'h0000_0000);
    `CHK(err, 1'b1)
  endtask
  task automatic t_write;
    logic seen;
    seen = 1'b0;
    xfer(1'b1, A_ADR, 32'h0000_0012);
    xfer(1'b1, A_DAT, 32'h0000_00a5);
    start(8'h06);
    `CHK(write_busy, 1'b1)
    xfer(1'b1, A_CTL, 32'h0000_0000);
    rd(A_CTL, 32'h0000_0002);
    rd(A_FLG, 32'h0000_0000);
    // programmer port watched for the erased byte until the write ends
    @(posedge pclk);
    prd <= 1'b1;
    pad <= 8'h12;
    while (write_busy === 1'b1) begin
      @(negedge pclk);
      if (prog_rdata === dee_pkg::ERASED_BYTE)
        seen = 1'b1;
    end
    @(posedge pclk);
    prd <= 1'b0;
    `CHK(seen, 1'b1)
    rd(A_FLG, 32'h0000_0080);
    xfer(1'b1, A_DAT, 32'h0000_0000);
    xfer(1'b1, A_CTL, 32'h0000_0001);
    rd(A_CTL, 32'h0000_0000);
    rd(A_DAT, 32'h0000_00a5);
    xfer(1'b1, A_ADR, 32'h0000_0013);
    rd(A_DAT, 32'h0000_00a5);
    xfer(1'b1, A_FLG, 32'h0000_0000);
    rd(A_FLG, 32'h0000_0000);
  endtask
  task automatic t_block;
    xfer(1'b1, A_ADR, 32'h0000_0012);
    xfer(1'b1, A_DAT, 32'h0000_005a);
    start(8'h06);
    `CHK(write_busy, 1'b0)
    xfer(1'b1, A_UNL, 32'h0000_0055);
    rd(A_UNL, 32'h0000_0000);
    xfer(1'b1, A_UNL, 32'h0000_00aa);
    xfer(1'b1, A_CTL, 32'h0000_0006);
    `CHK(write_busy, 1'b0)
    @(posedge pclk);
    ptb <= 1'b1;
    start(8'h06);
    `CHK(write_busy, 1'b0)
    @(posedge pclk);
    ptb <= 1'b0;
    xfer(1'b1, A_CTL, 32'h0000_0005);
    rd(A_DAT, 32'h0000_00a5);
  endtask
  task automatic t_prog;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      dps <= i[0];
      prd <= 1'b1;
      pad <= 8'h12;
      @(posedge pclk);
      prd <= 1'b0;
      @(negedge pclk);
      `CHK(prog_rdata, i ? 8'h00 : 8'ha5)
    end
  endtask
  task automatic t_abort;
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, A_ADR, 32'h0000_0030);
      xfer(1'b1, A_DAT, 32'h0000_003c);
      xfer(1'b1, A_CTL, 32'h0000_0004);
      start(8'h06);
      @(posedge pclk);
      {wdt, mc} <= i ? 2'b10 : 2'b01;
      @(posedge pclk);
      {wdt, mc} <= 2'b00;
      rd(A_CTL, 32'h0000_0008);
      rd(A_DAT, 32'h0000_0000);
      rd(A_ADR, 32'h0000_0000);
      rd(A_FLG, 32'h0000_0000);
      xfer(1'b1, A_CTL, 32'h0000_0000);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_write;
    t_block;
    t_prog;
    t_abort;
    stop_test;
  end
  initial begin
    #50000;
    mismatches++;
    stop_test;
  end
endmodule
